/* File: design/pbm_basic_mode_control.sv */
// basic mode control register of a 10/100 phy with its status access types
// assumes a management engine drives the register port synchronously to mclk
`timescale 1ns/1ps
`include "pbm_defines.svh"

module pbm_basic_mode_control #(
  parameter int unsigned RESET_HOLD_CYC = `PBM_SOFT_RESET_CYC,
  parameter int unsigned NUM_LH         = 2
) (
  // clock and reset
  input  logic                mclk,
  input  logic                rst,
  // management register port
  input  logic [4:0]          mgmt_addr,
  input  logic                mgmt_wr,
  input  logic                mgmt_rd,
  input  logic [15:0]         mgmt_wdata,
  output logic [15:0]         mgmt_rdata_q,
  // straps and mode inputs
  input  logic                strap_speed_100,
  input  logic                strap_full_duplex,
  input  logic                strap_an_enable,
  input  logic                fiber_mode_enable,
  // negotiation engine
  input  logic                an_restart_ack,
  input  logic                an_speed_100,
  input  logic                an_full_duplex,
  output logic                an_enable_q,
  output logic                an_restart_q,
  // port configuration
  output logic                speed_100_q,
  output logic                full_duplex_q,
  output logic                phy_power_down_q,
  output logic                phy_reset_q,
  // mii side
  input  pbm_pkg::pbm_mii_tx_t mac_tx,
  output pbm_pkg::pbm_mii_rx_t mac_rx_q,
  output logic                mac_col_q,
  // line side
  input  pbm_pkg::pbm_mii_rx_t line_rx,
  input  logic                line_col,
  output pbm_pkg::pbm_mii_tx_t line_tx_q,
  // status events
  input  logic [NUM_LH-1:0]   lh_event,
  input  logic                link_ok,
  input  logic                sc_event,
  input  logic                err_event
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic              loop_q;
  logic              speed_sel_q;
  logic              duplex_sel_q;
  logic              pdown_q;
  logic              iso_q;
  logic              coltest_q;
  logic              restart_d;
  logic              loop_d;
  logic              speed_sel_d;
  logic              duplex_sel_d;
  logic              an_en_d;
  logic              pdown_d;
  logic              iso_d;
  logic              coltest_d;
  logic              busy_q;
  logic              load;
  logic              wr_ctrl;
  logic              rd_stat;
  logic              sr_start;
  logic              wr_cfg;
  logic              an_en_wr;
  logic              restart_set;
  logic [NUM_LH-1:0] lh_q;
  logic              ll_q;
  logic [7:0]        cnt_q;
  logic [7:0]        cnt_d;
  logic [7:0]        cnt_inc;
  logic [15:0]       ctrl_word;
  logic [15:0]       stat_word;
  logic [15:0]       rdata_d;
  logic              mii_off;
  pbm_pkg::pbm_mii_rx_t rx_d;

  // address match, shared by write and read decode
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    hit = (addr == off);
  endfunction

  // ************************************************************
  // decode
  // ************************************************************
  assign wr_ctrl  = mgmt_wr & hit(mgmt_addr, `PBM_ADDR_CTRL);
  assign rd_stat  = mgmt_rd & hit(mgmt_addr, `PBM_ADDR_STAT);
  assign sr_start = wr_ctrl & mgmt_wdata[`PBM_B_RESET] & ~busy_q;
  assign wr_cfg   = wr_ctrl & ~mgmt_wdata[`PBM_B_RESET] & ~busy_q;
  assign an_en_wr = mgmt_wdata[`PBM_B_AN_EN] & ~fiber_mode_enable;

  // ************************************************************
  // soft reset sequencer
  // ************************************************************
  pbm_reset_seq #(
    .HOLD_CYC (RESET_HOLD_CYC)
  ) u_reset_seq (
    .mclk   (mclk),
    .rst    (rst),
    .start  (sr_start),
    .busy_q (busy_q),
    .load   (load)
  );

  // ************************************************************
  // control next values: strap load, then soft reset start, then write
  // ************************************************************
  // restrap on load
  assign speed_sel_d  = load ? strap_speed_100 : (wr_cfg ? mgmt_wdata[`PBM_B_SPEED] : speed_sel_q);
  assign duplex_sel_d = load ? strap_full_duplex : (wr_cfg ? mgmt_wdata[`PBM_B_DUPLEX] : duplex_sel_q);
  assign an_en_d      = ~fiber_mode_enable & (load ? strap_an_enable : (wr_cfg ? an_en_wr : an_enable_q));
  assign loop_d       = ~(load | sr_start) & (wr_cfg ? mgmt_wdata[`PBM_B_LOOP] : loop_q);
  assign pdown_d      = ~(load | sr_start) & (wr_cfg ? mgmt_wdata[`PBM_B_PDOWN] : pdown_q);
  assign iso_d        = ~(load | sr_start) & (wr_cfg ? mgmt_wdata[`PBM_B_ISO] : iso_q);
  assign coltest_d    = ~(load | sr_start) & (wr_cfg ? mgmt_wdata[`PBM_B_COLTEST] : coltest_q);

  assign restart_set  = wr_cfg & mgmt_wdata[`PBM_B_RESTART] & an_en_wr;
  assign restart_d    = restart_set | restart_keep_f(an_restart_q, an_restart_ack, load | sr_start);

  // every operand is an argument, so the assignment wakes on each change
  function automatic logic restart_keep_f(input logic r, input logic ack, input logic clr);
    restart_keep_f = r & ~ack & ~clr;
  endfunction

  // control registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      loop_q       <= 1'b0;
      speed_sel_q  <= 1'b0;
      duplex_sel_q <= 1'b0;
      an_enable_q  <= 1'b0;
      pdown_q      <= 1'b0;
      iso_q        <= 1'b0;
      coltest_q    <= 1'b0;
      an_restart_q <= 1'b0;
    end else begin
      loop_q       <= loop_d;
      speed_sel_q  <= speed_sel_d;
      duplex_sel_q <= duplex_sel_d;
      an_enable_q  <= an_en_d;
      pdown_q      <= pdown_d;
      iso_q        <= iso_d;
      coltest_q    <= coltest_d;
      an_restart_q <= restart_d;
    end
  end

  // ************************************************************
  // effective port configuration
  // ************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      speed_100_q      <= 1'b0;
      full_duplex_q    <= 1'b0;
      phy_power_down_q <= 1'b0;
      phy_reset_q      <= 1'b1;
    end else begin
      speed_100_q      <= an_enable_q ? an_speed_100 : speed_sel_q;
      full_duplex_q    <= an_enable_q ? an_full_duplex : duplex_sel_q;
      phy_power_down_q <= pdown_q;
      phy_reset_q      <= busy_q;
    end
  end

  // ************************************************************
  // mii data path
  // ************************************************************
  // isolate cuts mii
  assign mii_off = iso_q | pdown_q;
  assign rx_d    = mii_off ? '0 : (loop_q ? {mac_tx.en, mac_tx.er, mac_tx.data} : line_rx);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mac_rx_q  <= '0;
      line_tx_q <= '0;
      mac_col_q <= 1'b0;
    end else begin
      mac_rx_q  <= rx_d;
      line_tx_q <= (mii_off | loop_q) ? '0 : mac_tx;
      mac_col_q <= ~mii_off & (coltest_q ? mac_tx.en : line_col);
    end
  end

  // ************************************************************
  // status register cells
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LH; gi++) begin : g_lh
      pbm_status_bit #(
        .LATCH_LOW (1'b0)
      ) u_lh (
        .mclk (mclk),
        .rst  (rst),
        .cond (lh_event[gi]),
        .rd   (rd_stat),
        .q    (lh_q[gi])
      );
    end
  endgenerate

  pbm_status_bit #(
    .LATCH_LOW (1'b1)
  ) u_ll (
    .mclk (mclk),
    .rst  (rst),
    .cond (link_ok),
    .rd   (rd_stat),
    .q    (ll_q)
  );

  assign cnt_inc = (cnt_q == `PBM_CNT_MAX) ? cnt_q : cnt_q + `PBM_CNT_ONE;
  assign cnt_d   = rd_stat ? (err_event ? `PBM_CNT_ONE : `PBM_CNT_RESET) : (err_event ? cnt_inc : cnt_q);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= `PBM_CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  // reset bit reads busy
  assign ctrl_word = {busy_q, loop_q, speed_sel_q, an_enable_q, pdown_q, iso_q,
                      an_restart_q, duplex_sel_q, coltest_q, `PBM_CTRL_LOW_ZERO};
  assign stat_word = {cnt_q, `PBM_FIXED_CODE, sc_event, ll_q, lh_q};
  assign rdata_d   = hit(mgmt_addr, `PBM_ADDR_CTRL) ? ctrl_word :
                     hit(mgmt_addr, `PBM_ADDR_STAT) ? stat_word : 16'h0000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mgmt_rdata_q <= 16'h0000;
    end else if (mgmt_rd) begin
      mgmt_rdata_q <= rdata_d;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_sr_write;
    sr_start;
  endsequence

  sequence s_sr_busy;
    busy_q [*8];
  endsequence

  chk_soft_reset_busy: assert property (s_sr_write |=> s_sr_busy)
    else $error("soft reset bit did not read back as one");
  chk_restrap_speed: assert property (load |=> speed_sel_q == $past(strap_speed_100) && !busy_q)
    else $error("soft reset did not reload strapped speed");
  chk_loop_route: assert property (loop_q && !mii_off |=> mac_rx_q.data == $past(mac_tx.data))
    else $error("loopback did not route transmit data");
  chk_forced_speed: assert property (!an_enable_q |=> speed_100_q == $past(speed_sel_q))
    else $error("forced speed not applied");
  chk_an_speed: assert property (an_enable_q |=> speed_100_q == $past(an_speed_100))
    else $error("speed bit not ignored while negotiating");
  chk_fiber_no_an: assert property (fiber_mode_enable |=> !an_enable_q)
    else $error("negotiation enable set in fiber mode");
  chk_pdown_quiet: assert property (pdown_q |=> mac_rx_q == '0 && phy_power_down_q)
    else $error("phy active while powered down");
  chk_isolate_cut: assert property (iso_q |=> mac_rx_q == '0 && line_tx_q == '0)
    else $error("mii not isolated");
  chk_restart_ignored: assert property (wr_cfg && !an_en_wr && !an_restart_q |=> !an_restart_q)
    else $error("restart accepted with negotiation off");
  chk_restart_hold: assert property (an_restart_q && !an_restart_ack && !sr_start |=> an_restart_q)
    else $error("restart bit cleared before negotiation started");
  chk_restart_clear_ok: assert property (wr_cfg && !mgmt_wdata[9] && an_restart_q && !an_restart_ack
                                         |=> an_restart_q)
    else $error("written zero disturbed restart");
  chk_forced_duplex: assert property (!an_enable_q |=> full_duplex_q == $past(duplex_sel_q))
    else $error("forced duplex not applied");
  chk_col_assert: assert property (coltest_q && mac_tx.en && !mii_off ##1 coltest_q |-> mac_col_q)
    else $error("collision test did not raise col");
  chk_col_release: assert property (coltest_q && !mac_tx.en |=> !mac_col_q)
    else $error("collision test did not drop col");
  chk_sc_follow: assert property (mgmt_rd && hit(mgmt_addr, 5'h01) |=> mgmt_rdata_q[3] == $past(sc_event))
    else $error("self-clearing bit did not follow its event");
  chk_cor_clear: assert property (rd_stat && !err_event |=> cnt_q == 8'h00)
    else $error("read did not clear counter");
  chk_fixed_field: assert property (rd_stat |=> mgmt_rdata_q[7:4] == 4'hA)
    else $error("fixed field changed");

endmodule

/* File: design/pbm_defines.svh */
// register offsets, field positions, reset values and timing counts of the
// basic mode control block; assumes inclusion by bare name from design files
`ifndef PBM_DEFINES_SVH
`define PBM_DEFINES_SVH

// ************************************************************
// register offsets
// ************************************************************
`define PBM_ADDR_CTRL     5'h00
`define PBM_ADDR_STAT     5'h01

// ************************************************************
// control word fields
// ************************************************************
`define PBM_B_RESET       15
`define PBM_B_LOOP        14
`define PBM_B_SPEED       13
`define PBM_B_AN_EN       12
`define PBM_B_PDOWN       11
`define PBM_B_ISO         10
`define PBM_B_RESTART     9
`define PBM_B_DUPLEX      8
`define PBM_B_COLTEST     7
`define PBM_CTRL_LOW_ZERO 7'h00

// ************************************************************
// status word fields and reset values
// ************************************************************
`define PBM_S_LH_LO       0
`define PBM_S_LL          2
`define PBM_S_SC          3
`define PBM_S_FIX_LO      4
`define PBM_S_CNT_LO      8
`define PBM_FIXED_CODE    4'hA
`define PBM_CNT_RESET     8'h00
`define PBM_CNT_MAX       8'hFF
`define PBM_CNT_ONE       8'h01

// ************************************************************
// timing
// ************************************************************
`define PBM_CLK_NS        10
`define PBM_SOFT_RESET_NS 1000
`define PBM_SOFT_RESET_CYC ((`PBM_SOFT_RESET_NS + `PBM_CLK_NS - 1) / `PBM_CLK_NS)

`endif

/* File: design/pbm_pkg.sv */
// types shared by the basic mode control block and its helpers
// assumes nothing beyond a SystemVerilog compiler
package pbm_pkg;

  // ************************************************************
  // soft reset sequencer states, gray along idle-hold-load
  // ************************************************************
  typedef enum logic [1:0] {
    PBM_S_IDLE = 2'b00,
    PBM_S_HOLD = 2'b01,
    PBM_S_LOAD = 2'b11
  } pbm_rst_state_t;

  // mii transmit group from the mac
  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] data;
  } pbm_mii_tx_t;

  // mii receive group towards the mac
  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] data;
  } pbm_mii_rx_t;

endpackage

/* File: design/pbm_reset_seq.sv */
// soft reset sequencer: holds reset for a fixed count, then one strap-load cycle
// assumes start is a single-cycle request from the register block
`timescale 1ns/1ps
`include "pbm_defines.svh"

module pbm_reset_seq #(
  parameter int unsigned HOLD_CYC = `PBM_SOFT_RESET_CYC
) (
  // clock and reset
  input  logic mclk,
  input  logic rst,
  // control
  input  logic start,
  // status
  output logic busy_q,
  output logic load
);

  localparam int unsigned CW = $clog2(HOLD_CYC + 1);

  pbm_pkg::pbm_rst_state_t state_q;
  pbm_pkg::pbm_rst_state_t state_d;
  logic [CW-1:0]           cnt_q;
  logic [CW-1:0]           cnt_d;
  logic                    cnt_done;

  // ************************************************************
  // next state
  // ************************************************************
  assign cnt_done = (cnt_q == CW'(HOLD_CYC - 1));
  assign load     = (state_q == pbm_pkg::PBM_S_LOAD);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      pbm_pkg::PBM_S_IDLE: begin
        cnt_d = '0;
        if (start) begin
          state_d = pbm_pkg::PBM_S_HOLD;
        end
      end
      pbm_pkg::PBM_S_HOLD: begin
        cnt_d = cnt_q + CW'(1);
        if (cnt_done) begin
          state_d = pbm_pkg::PBM_S_LOAD;
        end
      end
      pbm_pkg::PBM_S_LOAD: begin
        state_d = pbm_pkg::PBM_S_IDLE;
      end
      default: begin
        state_d = pbm_pkg::PBM_S_IDLE;
      end
    endcase
  end

  // ************************************************************
  // state registers; hard reset starts in load so straps are caught after release
  // ************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= pbm_pkg::PBM_S_LOAD;
      cnt_q   <= '0;
      busy_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      busy_q  <= (state_d != pbm_pkg::PBM_S_IDLE);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_load_one_cycle: assert property (load |=> !load)
    else $error("strap load lasted more than one cycle");

endmodule

/* File: design/pbm_status_bit.sv */
// one latched status bit, latched-high or latched-low, cleared by a read
// assumes rd is a one-cycle read strobe of the owning register
`timescale 1ns/1ps

module pbm_status_bit #(
  parameter bit LATCH_LOW = 1'b0
) (
  // clock and reset
  input  logic mclk,
  input  logic rst,
  // event level and read strobe
  input  logic cond,
  input  logic rd,
  // latched value
  output logic q
);

  logic q_d;

  // latching, the event wins over a read in the same cycle
  generate
    if (LATCH_LOW) begin : g_ll
      assign q_d = cond & (q | rd);
    end else begin : g_lh
      assign q_d = cond | (q & ~rd);
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= 1'b0;
    end else begin
      q <= q_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  generate
    if (LATCH_LOW) begin : g_chk_ll
      chk_ll_holds_low: assert property (!cond |=> !q ##1 (!q || $past(rd)))
        else $error("latched-low bit rose without a read");
    end else begin : g_chk_lh
      chk_lh_holds_high: assert property (cond |=> q ##1 (q || $past(rd)))
        else $error("latched-high bit fell without a read");
    end
  endgenerate

endmodule

/* File: sim/pbm_mgmt_model.sv */
// management controller model: one-cycle write and read strobes on mclk
// assumes the register port samples strobes at the rising mclk edge
`timescale 1ns/1ps

module pbm_mgmt_model (
  // clock
  input  logic        mclk,
  // register port
  output logic [4:0]  mgmt_addr,
  output logic        mgmt_wr,
  output logic        mgmt_rd,
  output logic [15:0] mgmt_wdata,
  input  logic [15:0] mgmt_rdata_q
);
  // idle values; released data shows the inverse of the last word
  initial begin
    mgmt_addr  = 5'h1F;
    mgmt_wr    = 1'b0;
    mgmt_rd    = 1'b0;
    mgmt_wdata = 16'h0000;
  end

  // one write, strobe held over exactly one taking edge
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    mgmt_addr  <= a;
    mgmt_wdata <= d;
    mgmt_wr    <= 1'b1;
    @(posedge mclk);
    mgmt_wr    <= 1'b0;
    mgmt_wdata <= ~d;
  endtask

  // one read, data taken once the taking edge has landed
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk);
    mgmt_addr <= a;
    mgmt_rd   <= 1'b1;
    @(posedge mclk);
    mgmt_rd   <= 1'b0;
    #1 d = mgmt_rdata_q;
  endtask
endmodule

/* File: sim/pbm_basic_mode_control_test.sv */
// self-checking bench of the basic mode control block
// assumes the management model above drives the register port
`timescale 1ns/1ps

module pbm_basic_mode_control_test;
  typedef struct packed {logic [15:0] w; logic [15:0] r; logic [2:0] cfg;} pbm_row_t;
  logic mclk, rst, sp, fd, an, fib, ack, an_sp, an_fd, link_ok, sc_ev, err_ev;
  logic [4:0] addr;
  logic wr, rd;
  logic [15:0] wdata, rdata, d;
  logic an_en, an_rs, speed, duplex, pdown, preset, col, line_col;
  logic [1:0] lh_ev;
  pbm_pkg::pbm_mii_tx_t mac_tx, line_tx;
  pbm_pkg::pbm_mii_rx_t mac_rx, line_rx;
  int error_cnt, n_compared;
  // written word, read-back word, {speed, duplex, power down}
  pbm_row_t rows[9] = '{'{16'h2100, 16'h2100, 3'b110}, '{16'h0000, 16'h0000, 3'b000},
    '{16'h2000, 16'h2000, 3'b100}, '{16'h0100, 16'h0100, 3'b010}, '{16'h0800, 16'h0800, 3'b001},
    '{16'h047F, 16'h0400, 3'b000}, '{16'h4080, 16'h4080, 3'b000}, '{16'h3100, 16'h3100, 3'b000},
    '{16'h1000, 16'h1000, 3'b000}};

  pbm_mgmt_model mgmt (.mclk(mclk), .mgmt_addr(addr), .mgmt_wr(wr), .mgmt_rd(rd),
    .mgmt_wdata(wdata), .mgmt_rdata_q(rdata));
  pbm_basic_mode_control #(.RESET_HOLD_CYC(8)) dut (.mclk(mclk), .rst(rst), .mgmt_addr(addr),
    .mgmt_wr(wr), .mgmt_rd(rd), .mgmt_wdata(wdata), .mgmt_rdata_q(rdata), .strap_speed_100(sp),
    .strap_full_duplex(fd), .strap_an_enable(an), .fiber_mode_enable(fib), .an_restart_ack(ack),
    .an_speed_100(an_sp), .an_full_duplex(an_fd), .an_enable_q(an_en), .an_restart_q(an_rs),
    .speed_100_q(speed), .full_duplex_q(duplex), .phy_power_down_q(pdown), .phy_reset_q(preset),
    .mac_tx(mac_tx), .mac_rx_q(mac_rx), .mac_col_q(col), .line_rx(line_rx), .line_col(line_col),
    .line_tx_q(line_tx), .lh_event(lh_ev), .link_ok(link_ok), .sc_event(sc_ev), .err_event(err_ev));

  // compare one value and count it
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // counts, verdict and end of run
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // clock of 10 ns
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // hang guard, far beyond the roughly 120 cycles of the run
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end

  // main sequence
  initial begin
    {rst, sp, fd, an, fib, ack, an_sp, an_fd, link_ok, sc_ev, err_ev} = 11'b111_1000_0000;
    {mac_tx, lh_ev, line_col} = 9'h000;
    line_rx = 6'h2A;
    link_ok = 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    mgmt.rd(5'h00, d);
    chk(d, 16'h3100);
    chk({15'h0, preset}, 16'h0000);
    $display("test reset done");
    foreach (rows[i]) begin
      mgmt.wr(5'h00, rows[i].w);
      mgmt.rd(5'h00, d);
      chk(d, rows[i].r);
      chk({13'h0, speed, duplex, pdown}, {13'h0, rows[i].cfg});
    end
    $display("test table done");
    mgmt.wr(5'h00, 16'h4000);
    @(posedge mclk) mac_tx <= 6'h25;
    repeat (2) @(posedge mclk);
    // looped word only, no line data awaited
    #1 chk({10'h0, mac_rx}, 16'h0025);
    mgmt.wr(5'h00, 16'h0400);
    @(posedge mclk) line_col <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk({10'h0, line_tx}, 16'h0000);
    chk({9'h0, mac_rx, col}, 16'h0000);
    mgmt.wr(5'h00, 16'h0080);
    @(posedge mclk) {mac_tx, line_col} <= 7'h40;
    repeat (2) @(posedge mclk);
    #1 chk({15'h0, col}, 16'h0001);
    @(posedge mclk) mac_tx <= 6'h00;
    repeat (2) @(posedge mclk);
    #1 chk({15'h0, col}, 16'h0000);
    $display("test mii done");
    mgmt.wr(5'h00, 16'h1200);
    mgmt.wr(5'h00, 16'h1000);
    mgmt.rd(5'h00, d);
    chk(d, 16'h1200);
    @(posedge mclk) ack <= 1'b1;
    @(posedge mclk) ack <= 1'b0;
    mgmt.rd(5'h00, d);
    chk(d, 16'h1000);
    mgmt.wr(5'h00, 16'h0200);
    mgmt.rd(5'h00, d);
    chk({d[15:1], an_rs}, 16'h0000);
    $display("test restart done");
    @(posedge mclk) fib <= 1'b1;
    mgmt.wr(5'h00, 16'h4800);
    mgmt.wr(5'h00, 16'h8000);
    mgmt.rd(5'h00, d);
    chk({14'h0, d[15:14]}, 16'h0002);
    chk({15'h0, preset}, 16'h0001);
    repeat (12) @(posedge mclk);
    mgmt.rd(5'h00, d);
    chk(d, 16'h2100);
    chk({15'h0, an_en}, 16'h0000);
    @(posedge mclk) fib <= 1'b0;
    $display("test soft reset done");
    @(posedge mclk) {lh_ev, link_ok, sc_ev, err_ev} <= 5'b01011;
    repeat (3) @(posedge mclk);
    {lh_ev, link_ok, err_ev} <= 4'b0010;
    mgmt.rd(5'h01, d);
    chk(d, 16'h03A9);
    @(posedge mclk) sc_ev <= 1'b0;
    mgmt.wr(5'h01, 16'h0000);
    mgmt.rd(5'h01, d);
    chk(d, 16'h00A4);
    mgmt.rd(5'h1F, d);
    chk(d, 16'h0000);
    $display("test status done");
    report_and_stop();
  end
endmodule
